// [design/watchdog_pkg.sv]
// constants, field layout and types shared by the watchdog timer files
// assumes a 40 mhz aclk and a 32-bit axi4-lite master in front of the block
package watchdog_pkg;

    // ************************************************************
    // bus and register map
    // ************************************************************
    localparam int          ADDR_W       = 4;
    localparam int          DATA_W       = 32;
    localparam logic [3:0]  ADDR_CONTROL = 4'h0;
    localparam logic [3:0]  ADDR_STATUS  = 4'h4;
    localparam logic [3:0]  ADDR_MASK    = 4'h8;
    localparam logic [3:0]  ADDR_STATE   = 4'hc;
    localparam logic [1:0]  RESP_OKAY    = 2'h0;
    localparam logic [1:0]  RESP_SLVERR  = 2'h2;

    // ************************************************************
    // control register fields
    // ************************************************************
    localparam int          CTRL_W       = 8;
    localparam int          SWEN_BIT     = 0;
    localparam int          PS_LSB       = 1;
    localparam int          PS_W         = 5;
    localparam logic [7:0]  CTRL_RESET   = 8'h16;
    localparam logic [7:0]  CTRL_WMASK   = 8'h3f;

    // ************************************************************
    // period select and counter
    // ************************************************************
    localparam logic [4:0]  PS_MAX       = 5'h12;
    localparam logic [4:0]  SHIFT_BASE   = 5'h05;
    localparam int          CNT_W        = 23;

    // ************************************************************
    // event bits of status and mask
    // ************************************************************
    localparam int          EVT_W        = 2;
    localparam int          EVT_RESET    = 0;
    localparam int          EVT_WAKE     = 1;

    // ************************************************************
    // read-only state register fields
    // ************************************************************
    localparam int          ST_ACTIVE    = 0;
    localparam int          ST_ASLEEP    = 1;
    localparam int          ST_TO        = 2;
    localparam int          ST_PD        = 3;
    localparam int          ST_MODE_LSB  = 4;

    typedef enum logic [1:0] {
        MODE_OFF   = 2'b00,
        MODE_SW    = 2'b01,
        MODE_AWAKE = 2'b10,
        MODE_ON    = 2'b11
    } wdt_mode_t;

endpackage

// [design/pin_sync.sv]
// three-stage synchroniser for pins from outside the aclk domain
// assumes each pin level holds for two aclk edges or more, shorter ones never reach the output; output changes once stages two and three agree
`timescale 1ns/100ps
module pin_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             aclk,
    input  wire logic             aresetn,
    input  wire logic [WIDTH-1:0] pin,
    output logic      [WIDTH-1:0] level
);
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            logic s1_q, s2_q, s3_q, lvl_q;
            logic s1_d, s2_d, s3_d, lvl_d;
            always_comb begin
                s1_d  = pin[i];
                s2_d  = s1_q;
                s3_d  = s2_q;
                // a lone disagreement is held off for one more edge
                lvl_d = (s2_q == s3_q) ? s3_q : lvl_q;
            end
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    s1_q  <= 1'b0;
                    s2_q  <= 1'b0;
                    s3_q  <= 1'b0;
                    lvl_q <= 1'b0;
                end else begin
                    s1_q  <= s1_d;
                    s2_q  <= s2_d;
                    s3_q  <= s3_d;
                    lvl_q <= lvl_d;
                end
            end
            assign level[i] = lvl_q;
        end
    endgenerate
endmodule

// [design/watchdog_timer.sv]
// watchdog timer with axi4-lite control and status registers
// assumes a 40 mhz aclk, a 31 khz oscillator pin and same-clock sleep/osc signals
//
// Function
// - an expiry while awake raises a system reset.
// - the count advances only on ticks of the low-frequency oscillator.
// - mode 11 keeps the watchdog active always, sleep included.
// - mode 10 keeps it active awake and disabled in sleep.
// - mode 01 lets the software enable bit turn it on or off.
// - mode 00 disables it and the enable bit matters only in mode 01.
// - period code c sets the limit to two to the power five plus c ticks.
// - codes above 10010 give the minimum limit of 32 ticks.
// - reset restores the period code for 1:65536 and clears the enable bit.
// - reset, clear, sleep entry and exit, osc failure, disable and startup clear it.
// - the count clears on sleep entry and restarts from zero if still enabled.
// - the count clears on wake and stays clear while the startup timer runs.
// - an expiry in sleep wakes the device and updates the flags, no reset.
// - the oscillator divider setting has no path into the counter.
`timescale 1ns/100ps
module watchdog_timer (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [3:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    input  wire logic [3:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    input  wire logic        low_freq_internal_osc,
    input  wire logic [1:0]  watchdog_mode_cfg,
    input  wire logic        clear_watchdog_instruction,
    input  wire logic        sleep_active,
    input  wire logic        osc_fail,
    input  wire logic        osc_startup_timer,
    output logic             watchdog_reset,
    output logic             sleep_wake,
    output logic             timeout_status_flag,
    output logic             powerdown_status_flag,
    output logic             irq
);

    // ************************************************************
    // low-frequency tick
    // ************************************************************
    logic lf_level;

    pin_sync #(.WIDTH(1)) u_lf_sync (
        .aclk    (aclk),
        .aresetn (aresetn),
        .pin     (low_freq_internal_osc),
        .level   (lf_level)
    );

    // ************************************************************
    // watchdog core
    // ************************************************************
    watchdog_pkg::wdt_mode_t  mode_q;
    logic                     lf_prev_q, lf_prev_d;
    logic                     sleep_q, sleep_d;
    logic                     sleep_prev_q, sleep_prev_d;
    logic [watchdog_pkg::CNT_W-1:0] cnt_q, cnt_d, limit;
    logic                     reset_q, reset_d, wake_q, wake_d;
    logic                     to_q, to_d, pd_q, pd_d;
    logic                     lf_tick, active, enter, leave, clr, expire;
    logic [4:0]               ps, shift;
    logic [watchdog_pkg::CTRL_W-1:0] ctrl_q, ctrl_d;

    always_comb begin
        ps = ctrl_q[watchdog_pkg::PS_LSB +: watchdog_pkg::PS_W];
        // reserved codes fall back to minimum
        shift = (ps > watchdog_pkg::PS_MAX) ? watchdog_pkg::SHIFT_BASE
                                            : watchdog_pkg::SHIFT_BASE + ps;
        limit = (watchdog_pkg::CNT_W'(1) << shift) - watchdog_pkg::CNT_W'(1);
        case (mode_q)
            watchdog_pkg::MODE_ON:    active = 1'b1;
            watchdog_pkg::MODE_AWAKE: active = !sleep_q;
            watchdog_pkg::MODE_SW:    active = ctrl_q[watchdog_pkg::SWEN_BIT];
            watchdog_pkg::MODE_OFF:   active = 1'b0;
            default:                  active = 1'b0;
        endcase
        lf_tick      = lf_level && !lf_prev_q;
        enter        = sleep_q && !sleep_prev_q;
        leave        = !sleep_q && sleep_prev_q;
        // wake clears, startup timer holds clear
        clr          = clear_watchdog_instruction || enter || leave || osc_fail
                       || !active || osc_startup_timer;
        expire       = lf_tick && !clr && (cnt_q == limit);
        lf_prev_d    = lf_level;
        sleep_d      = sleep_active;
        sleep_prev_d = sleep_q;
        // no divider input reaches the count
        if (clr || expire) begin
            cnt_d = '0;
        end else if (lf_tick) begin
            cnt_d = cnt_q + watchdog_pkg::CNT_W'(1);
        end else begin
            cnt_d = cnt_q;
        end
        reset_d = expire && !sleep_q;
        wake_d  = expire && sleep_q;
        to_d    = expire ? 1'b0 : ((clear_watchdog_instruction || enter) ? 1'b1 : to_q);
        pd_d    = enter ? 1'b0 : (clear_watchdog_instruction ? 1'b1 : pd_q);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            // the strap is caught while reset is held, never mid-run
            mode_q       <= watchdog_pkg::wdt_mode_t'(watchdog_mode_cfg);
            lf_prev_q    <= 1'b0;
            sleep_q      <= 1'b0;
            sleep_prev_q <= 1'b0;
            cnt_q        <= '0;
            reset_q      <= 1'b0;
            wake_q       <= 1'b0;
            to_q         <= 1'b1;
            pd_q         <= 1'b1;
        end else begin
            lf_prev_q    <= lf_prev_d;
            sleep_q      <= sleep_d;
            sleep_prev_q <= sleep_prev_d;
            cnt_q        <= cnt_d;
            reset_q      <= reset_d;
            wake_q       <= wake_d;
            to_q         <= to_d;
            pd_q         <= pd_d;
        end
    end

    // ************************************************************
    // axi4-lite slave and registers
    // ************************************************************
    logic        aw_full_q, aw_full_d, w_full_q, w_full_d;
    logic [3:0]  awaddr_q, awaddr_d, wstrb_q, wstrb_d;
    logic [31:0] wdata_q, wdata_d, rdata_q, rdata_d;
    logic        awready_q, awready_d, wready_q, wready_d, arready_q, arready_d;
    logic        bvalid_q, bvalid_d, rvalid_q, rvalid_d;
    logic [1:0]  bresp_q, bresp_d, rresp_q, rresp_d;
    logic [watchdog_pkg::EVT_W-1:0] status_q, status_d, mask_q, mask_d, evt, rd_clr;
    logic        irq_q, irq_d, commit, ar_take;

    always_comb begin
        aw_full_d = aw_full_q;
        awaddr_d  = awaddr_q;
        w_full_d  = w_full_q;
        wdata_d   = wdata_q;
        wstrb_d   = wstrb_q;
        bvalid_d  = bvalid_q;
        bresp_d   = bresp_q;
        rvalid_d  = rvalid_q;
        rdata_d   = rdata_q;
        rresp_d   = rresp_q;
        ctrl_d    = ctrl_q;
        mask_d    = mask_q;
        rd_clr    = '0;
        if (awvalid && awready_q) begin
            aw_full_d = 1'b1;
            awaddr_d  = awaddr;
        end
        if (wvalid && wready_q) begin
            w_full_d = 1'b1;
            wdata_d  = wdata;
            wstrb_d  = wstrb;
        end
        if (bvalid_q && bready) begin
            bvalid_d = 1'b0;
        end
        commit = aw_full_q && w_full_q && !bvalid_q;
        if (commit) begin
            aw_full_d = 1'b0;
            w_full_d  = 1'b0;
            bvalid_d  = 1'b1;
            bresp_d   = watchdog_pkg::RESP_OKAY;
            case (awaddr_q)
                watchdog_pkg::ADDR_CONTROL: begin
                    if (wstrb_q[0]) begin
                        ctrl_d = wdata_q[watchdog_pkg::CTRL_W-1:0] & watchdog_pkg::CTRL_WMASK;
                    end
                end
                watchdog_pkg::ADDR_MASK: begin
                    if (wstrb_q[0]) begin
                        mask_d = wdata_q[watchdog_pkg::EVT_W-1:0];
                    end
                end
                watchdog_pkg::ADDR_STATUS: ;
                watchdog_pkg::ADDR_STATE:  ;
                default: bresp_d = watchdog_pkg::RESP_SLVERR;
            endcase
        end
        if (rvalid_q && rready) begin
            rvalid_d = 1'b0;
        end
        ar_take = arvalid && arready_q;
        if (ar_take) begin
            rvalid_d = 1'b1;
            rresp_d  = watchdog_pkg::RESP_OKAY;
            rdata_d  = '0;
            case (araddr)
                watchdog_pkg::ADDR_CONTROL: rdata_d[watchdog_pkg::CTRL_W-1:0] = ctrl_q;
                watchdog_pkg::ADDR_MASK:    rdata_d[watchdog_pkg::EVT_W-1:0] = mask_q;
                watchdog_pkg::ADDR_STATUS: begin
                    rdata_d[watchdog_pkg::EVT_W-1:0] = status_q;
                    rd_clr = status_q;
                end
                watchdog_pkg::ADDR_STATE: begin
                    rdata_d[watchdog_pkg::ST_ACTIVE] = active;
                    rdata_d[watchdog_pkg::ST_ASLEEP] = sleep_q;
                    rdata_d[watchdog_pkg::ST_TO]     = to_q;
                    rdata_d[watchdog_pkg::ST_PD]     = pd_q;
                    rdata_d[watchdog_pkg::ST_MODE_LSB +: 2] = mode_q;
                end
                default: rresp_d = watchdog_pkg::RESP_SLVERR;
            endcase
        end
        evt = '0;
        evt[watchdog_pkg::EVT_RESET] = reset_d;
        evt[watchdog_pkg::EVT_WAKE]  = wake_d;
        // an event in the cycle of the clearing read survives it
        status_d  = (status_q & ~rd_clr) | evt;
        irq_d     = |(status_d & mask_d);
        awready_d = !aw_full_d;
        wready_d  = !w_full_d;
        arready_d = !rvalid_d;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_q <= 1'b0;
            awaddr_q  <= '0;
            w_full_q  <= 1'b0;
            wdata_q   <= '0;
            wstrb_q   <= '0;
            awready_q <= 1'b0;
            wready_q  <= 1'b0;
            arready_q <= 1'b0;
            bvalid_q  <= 1'b0;
            bresp_q   <= watchdog_pkg::RESP_OKAY;
            rvalid_q  <= 1'b0;
            rdata_q   <= '0;
            rresp_q   <= watchdog_pkg::RESP_OKAY;
            ctrl_q    <= watchdog_pkg::CTRL_RESET;
            mask_q    <= '0;
            status_q  <= '0;
            irq_q     <= 1'b0;
        end else begin
            aw_full_q <= aw_full_d;
            awaddr_q  <= awaddr_d;
            w_full_q  <= w_full_d;
            wdata_q   <= wdata_d;
            wstrb_q   <= wstrb_d;
            awready_q <= awready_d;
            wready_q  <= wready_d;
            arready_q <= arready_d;
            bvalid_q  <= bvalid_d;
            bresp_q   <= bresp_d;
            rvalid_q  <= rvalid_d;
            rdata_q   <= rdata_d;
            rresp_q   <= rresp_d;
            ctrl_q    <= ctrl_d;
            mask_q    <= mask_d;
            status_q  <= status_d;
            irq_q     <= irq_d;
        end
    end

    assign awready               = awready_q;
    assign wready                = wready_q;
    assign bvalid                = bvalid_q;
    assign bresp                 = bresp_q;
    assign arready               = arready_q;
    assign rvalid                = rvalid_q;
    assign rdata                 = rdata_q;
    assign rresp                 = rresp_q;
    assign watchdog_reset        = reset_q;
    assign sleep_wake            = wake_q;
    assign timeout_status_flag   = to_q;
    assign powerdown_status_flag = pd_q;
    assign irq                   = irq_q;

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    sequence expire_awake_s;
        expire && !sleep_q;
    endsequence
    sequence expire_asleep_s;
        expire && sleep_q;
    endsequence
    sequence sleep_entry_s;
        !sleep_q ##1 sleep_q;
    endsequence

    expire_resets_a: assert property (expire_awake_s |=> watchdog_reset && !sleep_wake)
        else $error("awake expiry gave no reset");
    tick_only_a: assert property (!lf_tick && !clr |=> $stable(cnt_q))
        else $error("count moved without an oscillator tick");
    mode_on_a: assert property (mode_q == watchdog_pkg::MODE_ON |-> active)
        else $error("mode 11 not active");
    mode_awake_a: assert property (mode_q == watchdog_pkg::MODE_AWAKE && sleep_q |-> !active)
        else $error("mode 10 active in sleep");
    mode_soft_a: assert property (mode_q == watchdog_pkg::MODE_SW
                                  |-> active == ctrl_q[watchdog_pkg::SWEN_BIT])
        else $error("mode 01 ignores enable bit");
    mode_off_a: assert property (mode_q == watchdog_pkg::MODE_OFF |=> cnt_q == '0)
        else $error("mode 00 counts");
    period_limit_a: assert property (ps <= watchdog_pkg::PS_MAX
        |-> limit == (watchdog_pkg::CNT_W'(1) << (ps + 5'h05)) - watchdog_pkg::CNT_W'(1))
        else $error("wrong terminal count");
    reserved_min_a: assert property (ps > watchdog_pkg::PS_MAX |-> limit == 23'h00001f)
        else $error("reserved code not minimum");
    reset_value_a: assert property (@(posedge aclk) disable iff (1'b0)
        !aresetn |=> ctrl_q == watchdog_pkg::CTRL_RESET)
        else $error("control not at reset value");
    clear_count_a: assert property (clr |=> cnt_q == '0 && !watchdog_reset)
        else $error("clear did not zero the count");
    sleep_entry_a: assert property (sleep_entry_s |=> cnt_q == '0 && !powerdown_status_flag)
        else $error("sleep entry did not clear");
    startup_hold_a: assert property (osc_startup_timer [*3] |=> cnt_q == '0)
        else $error("count moved during startup timer");
    sleep_wake_a: assert property (expire_asleep_s
        |=> sleep_wake && !watchdog_reset && !timeout_status_flag)
        else $error("sleep expiry handled wrongly");
    limit_reached_a: assert property (expire |-> cnt_q == limit ##1 cnt_q == '0)
        else $error("expiry not at terminal count");

endmodule

// [tb/tb.sv]
// self-checking bench for the watchdog timer: registers, oscillator ticks, modes, sleep
// assumes the block's assertions live in its own files; the bench drives every port itself
`timescale 1ns/100ps
module tb;
    // ************************************************************
    // signals
    // ************************************************************
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [3:0]  awaddr = 4'h0;
    logic        awvalid = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [3:0]  wstrb = 4'h0;
    logic        wvalid = 1'b0;
    logic        bready = 1'b0;
    logic [3:0]  araddr = 4'h0;
    logic        arvalid = 1'b0;
    logic        rready = 1'b0;
    logic        low_freq_internal_osc = 1'b0;
    logic [1:0]  watchdog_mode_cfg = 2'h3;
    logic        clear_watchdog_instruction = 1'b0;
    logic        sleep_active = 1'b0;
    logic        osc_fail = 1'b0;
    logic        osc_startup_timer = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata;
    logic        watchdog_reset, sleep_wake, timeout_status_flag, powerdown_status_flag, irq;
    int          n_errors = 0;
    int          cmp_count = 0;
    int          n_rst = 0;
    int          n_wake = 0;
    int          cyc = 0;
    // pulse counts seen when a run starts; only the monitor writes n_rst and n_wake
    int          rst0 = 0;
    int          wake0 = 0;
    logic [4:0]  codes [5] = '{5'h00, 5'h01, 5'h02, 5'h13, 5'h1f};
    logic [31:0] r;

    always #12.5 aclk = ~aclk;

    watchdog_timer u_watchdog_timer (
        .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
        .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
        .rready, .low_freq_internal_osc, .watchdog_mode_cfg, .clear_watchdog_instruction,
        .sleep_active, .osc_fail, .osc_startup_timer, .watchdog_reset, .sleep_wake,
        .timeout_status_flag, .powerdown_status_flag, .irq
    );

    // ************************************************************
    // model, monitor and timeout
    // ************************************************************
    // expiry length in oscillator ticks; reserved codes fall back to the shortest
    function automatic int limit(input logic [4:0] c);
        return (c > 5'h12) ? 32 : (1 << (5 + c));
    endfunction

    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (aresetn && watchdog_reset === 1'b1) n_rst <= n_rst + 1;
        if (aresetn && sleep_wake === 1'b1) n_wake <= n_wake + 1;
        if (cyc == 60000) begin
            n_errors++;
            stop_test();
        end
    end

    task automatic stop_test();
        $display("compares %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    // ************************************************************
    // drivers
    // ************************************************************
    task automatic do_reset(input logic [1:0] m);
        aresetn <= 1'b0;
        watchdog_mode_cfg <= m;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (3) @(posedge aclk);
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
        bit ad;
        bit wd;
        ad = 0;
        wd = 0;
        // one idle edge keeps a back-to-back call from re-driving bready in one step
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hf;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(ad && wd)) begin
            @(posedge aclk);
            if (!ad && awready === 1'b1) begin
                ad = 1;
                awvalid <= 1'b0;
            end
            if (!wd && wready === 1'b1) begin
                wd = 1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (bvalid !== 1'b1);
        bready <= 1'b0;
        chk(bresp, er);
    endtask

    task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [1:0] er);
        // one idle edge keeps a back-to-back call from re-driving rready in one step
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge aclk); while (rvalid !== 1'b1);
        rready <= 1'b0;
        chk(rdata, e);
        chk(rresp, er);
    endtask

    task automatic tick(input int n);
        repeat (n) begin
            low_freq_internal_osc <= 1'b1;
            repeat (6) @(posedge aclk);
            low_freq_internal_osc <= 1'b0;
            repeat (6) @(posedge aclk);
        end
    endtask

    task automatic clr();
        clear_watchdog_instruction <= 1'b1;
        @(posedge aclk);
        clear_watchdog_instruction <= 1'b0;
        repeat (2) @(posedge aclk);
    endtask

    // tick n times from a known count, then compare pulses against the model
    task automatic run(input int n, input int er, input int ew);
        rst0 = n_rst;
        wake0 = n_wake;
        tick(n);
        chk(n_rst - rst0, er);
        chk(n_wake - wake0, ew);
    endtask

    task automatic period(input logic [4:0] c);
        wr(watchdog_pkg::ADDR_CONTROL, {26'h0, c, 1'b0}, watchdog_pkg::RESP_OKAY);
        clr();
        run(limit(c) - 1, 0, 0);
        tick(1);
        chk(n_rst - rst0, 1);
    endtask

    task automatic nap(input logic s);
        sleep_active <= s;
        repeat (3) @(posedge aclk);
    endtask

    // ************************************************************
    // tests
    // ************************************************************
    initial begin
        void'($urandom(32'h0b0e2e89));
        codes[3] = 5'h13 + 5'($urandom_range(0, 12));
        do_reset(2'b11);
        rd(watchdog_pkg::ADDR_CONTROL, 32'h16, 2'h0);
        rd(watchdog_pkg::ADDR_STATE, 32'h3d, 2'h0);
        rd(watchdog_pkg::ADDR_STATUS, 32'h0, 2'h0);
        rd(watchdog_pkg::ADDR_MASK, 32'h0, 2'h0);
        rd(4'h2, 32'h0, 2'h2);
        wr(4'h2, 32'h1, 2'h2);
        r = $urandom;
        wr(watchdog_pkg::ADDR_CONTROL, r, 2'h0);
        rd(watchdog_pkg::ADDR_CONTROL, r & 32'h3f, 2'h0);
        $display("test registers done");
        wr(watchdog_pkg::ADDR_MASK, 32'h1, 2'h0);
        foreach (codes[i]) period(codes[i]);
        chk(irq, 1'b1);
        chk(timeout_status_flag, 1'b0);
        rd(watchdog_pkg::ADDR_STATUS, 32'h1, 2'h0);
        repeat (2) @(posedge aclk);
        chk(irq, 1'b0);
        wr(watchdog_pkg::ADDR_MASK, 32'h0, 2'h0);
        run(32, 1, 0);
        chk(irq, 1'b0);
        rd(watchdog_pkg::ADDR_STATUS, 32'h1, 2'h0);
        $display("test periods done");
        clr();
        run(20, 0, 0);
        clr();
        chk(timeout_status_flag, 1'b1);
        run(31, 0, 0);
        tick(1);
        chk(n_rst - rst0, 1);
        clr();
        tick(20);
        nap(1'b1);
        run(31, 0, 0);
        tick(1);
        chk(n_wake - wake0, 1);
        chk(n_rst - rst0, 0);
        chk(powerdown_status_flag, 1'b0);
        chk(timeout_status_flag, 1'b0);
        tick(20);
        nap(1'b0);
        run(31, 0, 0);
        tick(1);
        chk(n_rst - rst0, 1);
        clr();
        osc_fail <= 1'b1;
        run(40, 0, 0);
        osc_fail <= 1'b0;
        osc_startup_timer <= 1'b1;
        run(40, 0, 0);
        osc_startup_timer <= 1'b0;
        run(32, 1, 0);
        $display("test clearing done");
        do_reset(2'b10);
        rd(watchdog_pkg::ADDR_CONTROL, 32'h16, 2'h0);
        wr(watchdog_pkg::ADDR_CONTROL, 32'h0, 2'h0);
        clr();
        nap(1'b1);
        run(40, 0, 0);
        nap(1'b0);
        run(32, 1, 0);
        do_reset(2'b01);
        wr(watchdog_pkg::ADDR_CONTROL, 32'h0, 2'h0);
        clr();
        run(40, 0, 0);
        wr(watchdog_pkg::ADDR_CONTROL, 32'h1, 2'h0);
        clr();
        nap(1'b1);
        run(32, 0, 1);
        nap(1'b0);
        do_reset(2'b00);
        wr(watchdog_pkg::ADDR_CONTROL, 32'h1, 2'h0);
        clr();
        run(40, 0, 0);
        rd(watchdog_pkg::ADDR_STATE, 32'h0c, 2'h0);
        $display("test modes done");
        stop_test();
    end
endmodule
